// ==== include/mtp_pkg.sv ====
// Shared constants and types of the multichannel timer core
package mtp_pkg;

  // Bus geometry
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
  localparam logic [AW-1:0] OFS_MODULO  = 8'h04;
  localparam logic [AW-1:0] OFS_INIT    = 8'h08;
  localparam logic [AW-1:0] OFS_COUNT   = 8'h0c;
  localparam logic [AW-1:0] OFS_SWOUT   = 8'h10;
  localparam logic [AW-1:0] OFS_PAIR    = 8'h14;
  localparam logic [AW-1:0] OFS_DEAD    = 8'h18;
  localparam logic [AW-1:0] OFS_STATUS  = 8'h1c;
  localparam logic [AW-1:0] OFS_CH_CTRL = 8'h20;
  localparam logic [AW-1:0] OFS_CH_VAL  = 8'h40;
  localparam logic [AW-1:0] CH_SPAN     = 8'h20;

  // Field positions
  localparam int unsigned CTRL_SRC_LSB  = 0;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_QUAD_BIT = 5;
  localparam int unsigned SW_VAL_LSB    = 8;
  localparam int unsigned PAIR_DT_LSB   = 4;
  localparam int unsigned PAIR_CMP_LSB  = 8;
  localparam int unsigned PAIR_INV_LSB  = 12;
  localparam int unsigned ST_TOF_BIT    = 0;
  localparam int unsigned ST_UP_BIT     = 1;
  localparam int unsigned ST_TOP_BIT    = 2;
  localparam int unsigned ST_FLT_LSB    = 4;
  localparam int unsigned CHC_CAP_LSB   = 2;

  // Reset values
  localparam logic [15:0] MODULO_RST = 16'hffff;

  // Clock source select
  typedef enum logic [1:0] {
    SRC_NONE  = 2'h0,
    SRC_SYS   = 2'h1,
    SRC_FIXED = 2'h2,
    SRC_EXT   = 2'h3
  } mtp_src_e;

  // Pwm operating modes
  typedef enum logic [2:0] {
    PM_EDGE       = 3'h0,
    PM_CENTER     = 3'h1,
    PM_EDGE_COMB  = 3'h2,
    PM_CENT_COMB  = 3'h3,
    PM_ASYM_COMB  = 3'h4
  } mtp_mode_e;

  // Edge level select codes, high bit then low bit
  localparam logic [1:0] ELS_OFF  = 2'h0;
  localparam logic [1:0] ELS_LOW  = 2'h1;
  localparam logic [1:0] ELS_HIGH = 2'h2;

  // Capture modes of a channel
  localparam logic [1:0] CAP_NONE = 2'h0;
  localparam logic [1:0] CAP_RISE = 2'h1;
  localparam logic [1:0] CAP_FALL = 2'h2;
  localparam logic [1:0] CAP_BOTH = 2'h3;

  // Avalon-MM request bundle
  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
    logic [3:0]    byteenable;
  } mtp_av_req_s;

endpackage

// ==== design/mtp_core.sv ====
// Summary of operation
// - Live count readable; a count above period reloads the initial value
// - Halted without clock source except in quadrature mode, runs once chosen
// - Capture latches count into channel value
// - Override enable replaces channel waveform
// - Override value drives one/zero; masks readable
// - Fault gating enabled per pair zero..three
// - Dead time inserted per enabled pair
// - Complementary pair: odd is inverted even
// - Inverting pair swaps the two outputs
// - Quadrature count wraps between low/high limits
// - Quadrature clear loads initial value
// - Direction and top/bottom overflow flags
// - Up to eight channels, count is parameter
// - Four fault input pins
// - Five pwm modes supported
// - Two-bit select: off, low-true, high-true
// - Edge low-true: low at overflow, high match
// - Center low-true: low down, high up
// - Center high-true: high down, low up
// - Combined low-true: high partner, low own
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module mtp_core #(
  parameter int unsigned NCH    = 8,
  parameter int unsigned CW     = 16,
  parameter int unsigned FIXDIV = 4,
  parameter int unsigned NFLT   = 4
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire mtp_pkg::mtp_av_req_s        av_req,
  output var  logic [mtp_pkg::DW-1:0]      av_readdata,
  output var  logic                        av_waitrequest,
  input  wire logic [NCH-1:0]              ch_in,
  input  wire logic [NFLT-1:0]             fault_in,
  input  wire logic                        phase_a,
  input  wire logic                        phase_b,
  input  wire logic                        ext_clk,
  output var  logic [NCH-1:0]              pwm_out
);
  import mtp_pkg::*;

  localparam int unsigned NP = NCH / 2;

  // Channel index of an address in a channel bank, or NCH when outside
  function automatic int unsigned ch_index(input logic [AW-1:0] a, input logic [AW-1:0] base);
    int unsigned r;
    r = NCH;
    if (a >= base && a < base + CH_SPAN && a[1:0] == 2'h0 && (32'(a - base) >> 2) < NCH) begin
      r = 32'(a - base) >> 2;
    end
    return r;
  endfunction

  // Pulse shape of one channel from count and compares
  function automatic logic shape(input logic [2:0] m, input logic [1:0] els,
                                 input logic [CW-1:0] c, input logic [CW-1:0] own,
                                 input logic [CW-1:0] pv);
    logic act;
    act = 1'b0;
    if (m == PM_EDGE || m == PM_CENTER) begin
      act = (c < own);
    end else begin
      act = (c >= own) && (c < pv);
    end
    if (els == ELS_HIGH) begin
      return act;
    end else if (els == ELS_LOW) begin
      return ~act;
    end
    return 1'b0;
  endfunction

  // Control registers
  logic [1:0]            src_q;
  logic [2:0]            mode_q;
  logic                  quad_q;
  logic [CW-1:0]         mod_q, init_q, cnt_q;
  logic [NCH-1:0]        swen_q, swval_q;
  logic [NP-1:0]         fen_q, dten_q, cmp_q, inv_q;
  logic [7:0]            dead_q;
  logic                  tof_q, up_q, top_q;
  logic [1:0]            els_q [NCH];
  logic [1:0]            capm_q [NCH];
  logic [CW-1:0]         val_q [NCH];

  // Bus handshake
  logic                  req, acc, wr_acc;
  int unsigned           wci, wvi, rci, rvi;
  logic [DW-1:0]         rd_d;

  assign req    = av_req.read | av_req.write;
  assign acc    = req & ~av_waitrequest;
  assign wr_acc = acc & av_req.write;
  assign wci    = ch_index(av_req.address, OFS_CH_CTRL);
  assign wvi    = ch_index(av_req.address, OFS_CH_VAL);
  assign rci    = wci;
  assign rvi    = wvi;

  // One wait cycle, then answer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      av_waitrequest <= 1'b1;
      av_readdata    <= '0;
    end else begin
      av_waitrequest <= ~(req & av_waitrequest);
      if (req & av_waitrequest) begin
        av_readdata <= rd_d;
      end
    end
  end

  // Synchronisers for pins
  logic [NCH-1:0]  ch_s1, ch_s2, ch_p;
  logic [NFLT-1:0] f_s1, f_s2;
  logic [2:0]      q_s1, q_s2, q_p;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ch_s1 <= '0; ch_s2 <= '0; ch_p <= '0;
      f_s1 <= '0; f_s2 <= '0;
      q_s1 <= '0; q_s2 <= '0; q_p <= '0;
    end else begin
      ch_s1 <= ch_in;
      ch_s2 <= ch_s1;
      ch_p  <= ch_s2;
      f_s1  <= fault_in;
      f_s2  <= f_s1;
      q_s1  <= {ext_clk, phase_b, phase_a};
      q_s2  <= q_s1;
      q_p   <= q_s2;
    end
  end

  // Read mux, unmapped reads give zero
  always_comb begin
    rd_d = '0;
    case (av_req.address)
      OFS_CTRL:   rd_d = DW'({quad_q, mode_q, src_q});
      OFS_MODULO: rd_d = DW'(mod_q);
      OFS_INIT:   rd_d = DW'(init_q);
      OFS_COUNT:  rd_d = DW'(cnt_q);
      OFS_SWOUT:  rd_d = DW'({swval_q, swen_q});
      OFS_PAIR:   rd_d = DW'({inv_q, cmp_q, dten_q, fen_q});
      OFS_DEAD:   rd_d = DW'(dead_q);
      OFS_STATUS: rd_d = DW'({f_s2, 1'b0, top_q, up_q, tof_q});
      default: begin
        if (rci < NCH) rd_d = DW'({capm_q[rci], els_q[rci]});
        else if (rvi < NCH) rd_d = DW'(val_q[rvi]);
      end
    endcase
  end

  // Global control writes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      src_q <= SRC_NONE; mode_q <= PM_EDGE; quad_q <= 1'b0;
      mod_q <= MODULO_RST[CW-1:0]; init_q <= '0;
      swen_q <= '0; swval_q <= '0; dead_q <= '0;
      fen_q <= '0; dten_q <= '0; cmp_q <= '0; inv_q <= '0;
    end else if (wr_acc) begin
      case (av_req.address)
        OFS_CTRL: begin
          src_q  <= av_req.writedata[CTRL_SRC_LSB +: 2];
          mode_q <= av_req.writedata[CTRL_MODE_LSB +: 3];
          quad_q <= av_req.writedata[CTRL_QUAD_BIT];
        end
        OFS_MODULO: mod_q <= av_req.writedata[CW-1:0];
        OFS_INIT:   init_q <= av_req.writedata[CW-1:0];
        OFS_SWOUT: begin
          swen_q  <= av_req.writedata[NCH-1:0];
          swval_q <= av_req.writedata[SW_VAL_LSB +: NCH];
        end
        OFS_PAIR: begin
          fen_q  <= av_req.writedata[NP-1:0];
          dten_q <= av_req.writedata[PAIR_DT_LSB +: NP];
          cmp_q  <= av_req.writedata[PAIR_CMP_LSB +: NP];
          inv_q  <= av_req.writedata[PAIR_INV_LSB +: NP];
        end
        OFS_DEAD: dead_q <= av_req.writedata[7:0];
        default: ;
      endcase
    end
  end

  // Counter clock: system, divided fixed clock, or external edge
  logic [7:0] div_q;
  logic       fix_tick, tick;
  assign fix_tick = (div_q == 8'(FIXDIV - 1));
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) div_q <= '0;
    else div_q <= fix_tick ? 8'h00 : div_q + 8'h01;
  end
  always_comb begin
    case (src_q)
      SRC_SYS:   tick = 1'b1;
      SRC_FIXED: tick = fix_tick;
      SRC_EXT:   tick = q_s2[2] & ~q_p[2];
      default:   tick = 1'b0;
    endcase
  end

  // Quadrature step and direction from phase a/b
  logic q_step, q_up, at_top, at_bot, ctr_mode, clr_cnt, tof_set;
  assign q_step  = (q_s2[0] ^ q_p[0]) | (q_s2[1] ^ q_p[1]);
  assign q_up    = q_s2[0] ^ q_p[1];
  assign at_top  = (cnt_q >= mod_q);
  assign at_bot  = (cnt_q <= init_q);
  assign ctr_mode = (mode_q == PM_CENTER) || (mode_q == PM_CENT_COMB);
  assign clr_cnt = wr_acc && (av_req.address == OFS_COUNT);
  assign tof_set = quad_q ? (q_step && (q_up ? at_top : at_bot))
                          : (tick && (ctr_mode ? (!up_q && at_bot) : at_top));

  // Main counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      up_q  <= 1'b1;
      top_q <= 1'b0;
    end else if (clr_cnt) begin
      cnt_q <= init_q;
      up_q  <= 1'b1;
    end else if (cnt_q > mod_q) begin
      cnt_q <= init_q;
    end else if (quad_q) begin
      if (q_step) begin
        up_q <= q_up;
        if (q_up && at_top) begin
          cnt_q <= init_q;
          top_q <= 1'b1;
        end else if (!q_up && at_bot) begin
          cnt_q <= mod_q;
          top_q <= 1'b0;
        end else begin
          cnt_q <= q_up ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end
      end
    end else if (tick) begin
      if (ctr_mode) begin
        if (up_q && at_top) begin
          up_q  <= 1'b0;
          cnt_q <= (mod_q > init_q) ? cnt_q - 1'b1 : cnt_q;
        end else if (!up_q && at_bot) begin
          up_q  <= 1'b1;
          cnt_q <= (mod_q > init_q) ? cnt_q + 1'b1 : cnt_q;
        end else begin
          cnt_q <= up_q ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end
      end else begin
        up_q  <= 1'b1;
        cnt_q <= at_top ? init_q : cnt_q + 1'b1;
      end
    end
  end

  // Overflow flag, write one to clear, set wins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) tof_q <= 1'b0;
    else if (tof_set) tof_q <= 1'b1;
    else if (wr_acc && av_req.address == OFS_STATUS && av_req.writedata[ST_TOF_BIT]) tof_q <= 1'b0;
  end

  // Per channel control, value and capture
  logic [NCH-1:0] wave, cap_evt;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign cap_evt[gi] = (capm_q[gi] == CAP_BOTH && (ch_s2[gi] ^ ch_p[gi])) ||
                           (capm_q[gi] == CAP_RISE && ch_s2[gi] && !ch_p[gi]) ||
                           (capm_q[gi] == CAP_FALL && !ch_s2[gi] && ch_p[gi]);
      assign wave[gi] = (capm_q[gi] != CAP_NONE) ? 1'b0 :
                        shape(mode_q, els_q[gi], cnt_q, val_q[gi],
                              val_q[gi | 1]);
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          els_q[gi]  <= ELS_OFF;
          capm_q[gi] <= CAP_NONE;
          val_q[gi]  <= '0;
        end else begin
          if (wr_acc && wci == gi) begin
            els_q[gi]  <= av_req.writedata[1:0];
            capm_q[gi] <= av_req.writedata[CHC_CAP_LSB +: 2];
          end
          if (cap_evt[gi]) val_q[gi] <= cnt_q;
          else if (wr_acc && wvi == gi) val_q[gi] <= av_req.writedata[CW-1:0];
        end
      end
      a_cap_latch: assert property (@(posedge ref_clk) disable iff (reset)
        cap_evt[gi] |=> val_q[gi] == $past(cnt_q))
        else $error("capture did not latch count");
    end
  endgenerate

  // Pair stage: combine, complement, dead time, swap, override, fault
  logic [NCH-1:0] pre_dt, post_dt, sw_lvl, fin;
  logic           fault_act;
  assign fault_act = |f_s2;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pair
      logic comb;
      assign comb = (mode_q == PM_EDGE_COMB) || (mode_q == PM_CENT_COMB) ||
                    (mode_q == PM_ASYM_COMB);
      assign pre_dt[2*gi]   = wave[2*gi];
      assign pre_dt[2*gi+1] = cmp_q[gi] ? ~wave[2*gi] :
                              (comb ? wave[2*gi] : wave[2*gi+1]);
      assign sw_lvl[2*gi]   = inv_q[gi] ? post_dt[2*gi+1] : post_dt[2*gi];
      assign sw_lvl[2*gi+1] = inv_q[gi] ? post_dt[2*gi] : post_dt[2*gi+1];
    end
    for (gi = 0; gi < NCH; gi++) begin : g_dt
      logic [7:0] dt_q;
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) dt_q <= '0;
        else if (!pre_dt[gi]) dt_q <= '0;
        else if (dt_q < dead_q) dt_q <= dt_q + 8'h01;
      end
      // Rising edges held back by the dead interval
      assign post_dt[gi] = pre_dt[gi] && (!dten_q[gi/2] || dt_q >= dead_q);
      assign fin[gi] = (fen_q[gi/2] && fault_act) ? 1'b0 :
                       (swen_q[gi] ? swval_q[gi] : sw_lvl[gi]);
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) pwm_out[gi] <= 1'b0;
        else pwm_out[gi] <= fin[gi];
      end
      a_sw_force: assert property (@(posedge ref_clk) disable iff (reset)
        (swen_q[gi] && !(fen_q[gi/2] && fault_act)) |=> pwm_out[gi] == $past(swval_q[gi]))
        else $error("override value not on output");
      a_fault_gate: assert property (@(posedge ref_clk) disable iff (reset)
        (fen_q[gi/2] && fault_act) |=> !pwm_out[gi])
        else $error("fault did not gate output");
      // Level held back right after a low level
      a_dead_gap: assert property (@(posedge ref_clk) disable iff (reset)
        (dten_q[gi/2] && dead_q != 8'h00 && !pre_dt[gi]) |=>
          (!post_dt[gi] || !dten_q[gi/2] || dead_q == 8'h00))
        else $error("dead interval not inserted");
    end
  endgenerate

  a_cnt_range: assert property (@(posedge ref_clk) disable iff (reset)
    (mod_q == $past(mod_q) && $past(cnt_q) <= $past(mod_q)) |-> cnt_q <= mod_q)
    else $error("count above period");
  a_halt_nosrc: assert property (@(posedge ref_clk) disable iff (reset)
    (src_q == SRC_NONE && !quad_q && !clr_cnt && cnt_q <= mod_q) |=> $stable(cnt_q))
    else $error("count moved without source");
  a_edge_reload: assert property (@(posedge ref_clk) disable iff (reset)
    (!quad_q && !ctr_mode && tick && !clr_cnt && cnt_q == mod_q) |=> cnt_q == $past(init_q))
    else $error("no reload at modulo");
  a_quad_wrap: assert property (@(posedge ref_clk) disable iff (reset)
    (quad_q && q_step && !q_up && !clr_cnt && cnt_q == init_q && cnt_q <= mod_q)
      |=> cnt_q == $past(mod_q) && !top_q)
    else $error("quadrature low wrap wrong");
  a_clear_init: assert property (@(posedge ref_clk) disable iff (reset)
    clr_cnt |=> cnt_q == $past(init_q))
    else $error("clear did not load initial");
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (reset)
    (req && av_waitrequest) |=> !av_waitrequest ##1 av_waitrequest)
    else $error("bus answer not one cycle");

  // Quadrature top wrap, direction and overflow flag
  a_quad_top: assert property (@(posedge ref_clk) disable iff (reset)
    (quad_q && q_step && q_up && !clr_cnt && at_top && cnt_q <= mod_q)
      |=> cnt_q == $past(init_q) && top_q)
    else $error("quadrature high wrap wrong");
  a_quad_dir: assert property (@(posedge ref_clk) disable iff (reset)
    (quad_q && q_step && !clr_cnt && cnt_q <= mod_q) |=> up_q == $past(q_up))
    else $error("direction flag wrong");
  a_tof_set: assert property (@(posedge ref_clk) disable iff (reset)
    tof_set |=> tof_q)
    else $error("overflow flag not set");

endmodule
`default_nettype wire

// ==== tb/mtp_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far side of the timer: encoder phases, fault pins, capture pins, count clock
module mtp_far_model (
  input  wire logic       ref_clk,
  output var  logic [7:0] ch_in,
  output var  logic [3:0] fault_in,
  output var  logic       phase_a,
  output var  logic       phase_b,
  output var  logic       ext_clk
);
  logic [1:0] pos;

  // Quiet lines at time zero
  initial begin
    pos = 2'h0;
    ch_in = '0;
    fault_in = '0;
    phase_a = 1'b0;
    phase_b = 1'b0;
    ext_clk = 1'b0;
  end

  // One encoder step, forward or back; only one phase moves, held past the synchroniser
  task automatic quad_step(input logic fwd);
    pos = fwd ? pos + 2'h1 : pos - 2'h1;
    @(posedge ref_clk);
    phase_a <= pos[1] ^ pos[0];
    phase_b <= pos[1];
    repeat (8) @(posedge ref_clk);
  endtask

  // Capture pin level, held until sampled
  task automatic pin(input int k, input logic v);
    @(posedge ref_clk);
    ch_in[k] <= v;
    repeat (8) @(posedge ref_clk);
  endtask

  // Fault pin level, active high
  task automatic fault(input int k, input logic v);
    @(posedge ref_clk);
    fault_in[k] <= v;
    repeat (8) @(posedge ref_clk);
  endtask

  // Slow count clock pulses, high for four cycles, then low for at least four
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mtp_pkg::*;
  logic              ref_clk;
  logic              reset;
  mtp_av_req_s       av_req;
  logic [DW-1:0]     av_readdata;
  logic              av_waitrequest;
  logic [7:0]        ch_in;
  logic [7:0]        pwm_out;
  logic [3:0]        fault_in;
  logic              phase_a;
  logic              phase_b;
  logic              ext_clk;
  logic [31:0]       rd;
  int                fail_count;
  int                total_checks;

  mtp_core i_mtp_core (
    .ref_clk(ref_clk), .reset(reset), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .ch_in(ch_in), .fault_in(fault_in),
    .phase_a(phase_a), .phase_b(phase_b), .ext_clk(ext_clk), .pwm_out(pwm_out));

  mtp_far_model i_far (
    .ref_clk(ref_clk), .ch_in(ch_in), .fault_in(fault_in),
    .phase_a(phase_a), .phase_b(phase_b), .ext_clk(ext_clk));

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    av_req.read <= !wr;
    av_req.write <= wr;
    av_req.address <= a;
    av_req.writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 50);
    rd = av_readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    if (av_waitrequest !== 1'b0) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // High cycles of one output over whole periods
  task automatic duty(input int ch, input int cyc, input int exp);
    int hi;
    hi = 0;
    repeat (4) @(posedge ref_clk);
    repeat (cyc) begin
      @(posedge ref_clk);
      if (pwm_out[ch] === 1'b1) hi++;
    end
    chk(32'(hi), 32'(exp));
  endtask

  task automatic t_reset();
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_MODULO, {16'h0, MODULO_RST});
    rdc(OFS_COUNT, 32'h0);
    rdc(8'hfc, 32'h0);
  endtask

  task automatic t_halt();
    wr(OFS_MODULO, 32'h9);
    repeat (20) @(posedge ref_clk);
    rdc(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h3);
    i_far.ext_pulses(5);
    rdc(OFS_COUNT, 32'h5);
    wr(OFS_INIT, 32'h7);
    wr(OFS_COUNT, 32'h0);
    i_far.ext_pulses(3);
    rdc(OFS_COUNT, 32'h7);
    wr(OFS_INIT, 32'h0);
    // Fixed source for 32 edges: one tick per four edges
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h2);
    repeat (29) @(posedge ref_clk);
    wr(OFS_CTRL, 32'h0);
    rdc(OFS_COUNT, 32'h8);
  endtask

  task automatic t_pwm();
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CH_VAL, 32'h3);
    wr(OFS_CH_CTRL, {30'h0, ELS_OFF});
    duty(0, 100, 0);
    wr(OFS_CH_CTRL, {30'h0, ELS_LOW});
    duty(0, 100, 70);
    wr(OFS_CH_CTRL, {30'h0, ELS_HIGH});
    duty(0, 100, 30);
    wr(OFS_CTRL, 32'h5);
    duty(0, 180, 50);
    wr(OFS_CH_CTRL, {30'h0, ELS_LOW});
    duty(0, 180, 130);
    wr(OFS_CTRL, 32'h9);
    wr(OFS_CH_VAL, 32'h2);
    wr(OFS_CH_VAL + 8'h04, 32'h6);
    duty(0, 100, 60);
    wr(OFS_CTRL, 32'hd);
    duty(0, 180, 100);
    wr(OFS_CTRL, 32'h11);
    duty(0, 100, 60);
  endtask

  task automatic t_pair();
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CH_VAL, 32'h3);
    wr(OFS_CH_CTRL, {30'h0, ELS_HIGH});
    wr(OFS_CH_CTRL + 8'h04, {30'h0, ELS_HIGH});
    wr(OFS_PAIR, 32'h100);
    duty(1, 100, 70);
    wr(OFS_PAIR, 32'h1100);
    duty(0, 100, 70);
    wr(OFS_DEAD, 32'h2);
    wr(OFS_PAIR, 32'h110);
    duty(0, 100, 10);
    duty(1, 100, 50);
  endtask

  task automatic t_override();
    wr(OFS_PAIR, 32'h1);
    wr(OFS_SWOUT, 32'hffff);
    repeat (4) @(posedge ref_clk);
    chk({24'h0, pwm_out}, 32'hff);
    rdc(OFS_SWOUT, 32'hffff);
    i_far.fault(3, 1'b1);
    chk({24'h0, pwm_out}, 32'hfc);
    i_far.fault(3, 1'b0);
    chk({24'h0, pwm_out}, 32'hff);
    wr(OFS_SWOUT, 32'h5aff);
    repeat (4) @(posedge ref_clk);
    chk({24'h0, pwm_out}, 32'h5a);
    wr(OFS_SWOUT, 32'h0);
  endtask

  task automatic t_capture();
    logic [31:0] held;
    wr(OFS_CTRL, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0);
    held = rd;
    wr(OFS_CH_VAL + 8'h08, 32'haa);
    wr(OFS_CH_CTRL + 8'h08, {28'h0, CAP_RISE, 2'h0});
    i_far.pin(2, 1'b1);
    rdc(OFS_CH_VAL + 8'h08, held);
    wr(OFS_CH_VAL + 8'h08, 32'haa);
    wr(OFS_CH_CTRL + 8'h08, {28'h0, CAP_FALL, 2'h0});
    i_far.pin(2, 1'b0);
    rdc(OFS_CH_VAL + 8'h08, held);
  endtask

  task automatic t_quad();
    wr(OFS_INIT, 32'h4);
    wr(OFS_MODULO, 32'h7);
    wr(OFS_CTRL, 32'h21);
    wr(OFS_COUNT, 32'h0);
    rdc(OFS_COUNT, 32'h4);
    repeat (3) i_far.quad_step(1'b1);
    rdc(OFS_COUNT, 32'h7);
    i_far.quad_step(1'b1);
    rdc(OFS_COUNT, 32'h4);
    rdc(OFS_STATUS, 32'h7);
    wr(OFS_STATUS, 32'h1);
    rdc(OFS_STATUS, 32'h6);
    i_far.quad_step(1'b0);
    rdc(OFS_COUNT, 32'h7);
    rdc(OFS_STATUS, 32'h1);
  endtask

  // Counts, verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end

  // Reset, then every scenario in turn
  initial begin
    fail_count = 0;
    total_checks = 0;
    reset = 1'b1;
    av_req = '0;
    av_req.byteenable = 4'hf;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_halt();
    t_pwm();
    t_pair();
    t_override();
    t_capture();
    t_quad();
    finish_test();
  end
endmodule
`default_nettype wire
